// ===== design/pfce_defs.vh
// pfce_defs.vh: constants for the parallel flash command host
// assumes: included by the host design files only
`ifndef PFCE_DEFS_VH
`define PFCE_DEFS_VH

`define PFCE_ADDR_W 17
`define PFCE_DATA_W 8
`define PFCE_UNLOCK1_ADDR 12'h555
`define PFCE_UNLOCK2_ADDR 12'haaa
`define PFCE_UNLOCK1_DATA 8'haa
`define PFCE_UNLOCK2_DATA 8'h55
`define PFCE_SETUP_ERASE 8'h80
`define PFCE_CONF_CHIP 8'h10
`define PFCE_CONF_SECTOR 8'h30
`define PFCE_CONF_LOCK 8'h40
`define PFCE_ERASED_BYTE 8'hff
`define PFCE_PARAM1_BASE 17'h04000
`define PFCE_PARAM1_LAST 17'h05fff
// operation codes on i_cmd_op
`define PFCE_OP_READ 3'h0
`define PFCE_OP_CHIP 3'h1
`define PFCE_OP_SECTOR 3'h2
`define PFCE_OP_LOCK 3'h3
`define PFCE_OP_RESET 3'h4
// pin timing, ns, and derived cycle counts at 40 MHz
`define PFCE_CLK_NS 25
`define PFCE_SETUP_NS 30
`define PFCE_SETUP_CYC ((`PFCE_SETUP_NS + `PFCE_CLK_NS - 1) / `PFCE_CLK_NS)
`define PFCE_PULSE_NS 50
`define PFCE_PULSE_CYC ((`PFCE_PULSE_NS + `PFCE_CLK_NS - 1) / `PFCE_CLK_NS)
`define PFCE_ACCESS_NS 55
`define PFCE_ACCESS_CYC ((`PFCE_ACCESS_NS + `PFCE_CLK_NS - 1) / `PFCE_CLK_NS)
`define PFCE_RESET_NS 500
`define PFCE_RESET_CYC ((`PFCE_RESET_NS + `PFCE_CLK_NS - 1) / `PFCE_CLK_NS)
// chip erase maximum, ms; derived count goes to a top parameter
`define PFCE_CHIP_ERASE_MS 3000
`define PFCE_CHIP_ERASE_CYC (`PFCE_CHIP_ERASE_MS * 40000)

`endif

// ===== design/pfce_timer.v
// pfce_timer.v: down counter that measures pin phases and erase waits
// assumes: one clock domain; i_load takes priority over counting
`timescale 1ns/1ps
module pfce_timer #(
  parameter W = 32
) (
  input wire i_clk,
  input wire i_reset,
  input wire i_load,
  input wire [W-1:0] i_count,
  output wire o_done
);
  reg [W-1:0] cnt_q;
  reg [W-1:0] cnt_d;

  always @*
  begin
    cnt_d = cnt_q;
    if (i_load)
      cnt_d = i_count;
    else if (cnt_q != {W{1'b0}})
      cnt_d = cnt_q - {{(W-1){1'b0}}, 1'b1};
  end

  always @(posedge i_clk)
  begin
    if (i_reset)
      cnt_q <= {W{1'b0}};
    else
      cnt_q <= cnt_d;
  end

  // done must not look at i_load: callers reload on done, which would close a loop
  assign o_done = (cnt_q == {W{1'b0}});
endmodule

// ===== design/pfce_host.v
// pfce_host.v: host controller driving a byte-wide parallel flash by its pins
// assumes: flash pins are asynchronous; byte_data_lines read back via two flops
//
// Operation
// - host pulses strobe low, select low, gate high
// - chip erase is six load cycles
// - sector erase takes six bus cycles
// - sequences open with two unlock cycles
`timescale 1ns/1ps
`include "pfce_defs.vh"
module pfce_host #(
  parameter AW = `PFCE_ADDR_W,
  parameter DW = `PFCE_DATA_W,
  parameter ERASE_CYC = `PFCE_CHIP_ERASE_CYC,
  parameter SECTOR_CYC = `PFCE_CHIP_ERASE_CYC
) (
  input wire i_clk,
  input wire i_reset,
  input wire i_cmd_valid,
  input wire [2:0] i_cmd_op,
  input wire [AW-1:0] i_cmd_addr,
  input wire i_override,
  output reg o_cmd_ready,
  output reg o_rd_valid,
  output reg [DW-1:0] o_rd_data,
  output reg o_done,
  output reg [AW-1:0] o_flash_addr,
  output reg [DW-1:0] o_flash_dq_out,
  output reg o_flash_dq_oe,
  input wire [DW-1:0] i_flash_dq_in,
  output reg o_flash_select_n,
  output reg o_flash_gate_n,
  output reg o_flash_strobe_n,
  output reg o_flash_reset_n,
  output reg o_flash_override
);
  localparam TW = 32;
  localparam S_IDLE = 3'h0;
  localparam S_SETUP = 3'h1;
  localparam S_PULSE = 3'h2;
  localparam S_HOLD = 3'h3;
  localparam S_RSETUP = 3'h4;
  localparam S_RWAIT = 3'h5;
  localparam S_ERASE = 3'h6;
  localparam S_RESET = 3'h7;

  reg [2:0] st_q;
  reg [2:0] op_q;
  reg [2:0] step_q;
  reg [AW-1:0] addr_q;
  reg [DW-1:0] dq_s1_q;
  reg [DW-1:0] dq_s2_q;
  reg tload;
  reg [TW-1:0] tcount;
  wire tdone;
  reg [AW-1:0] cyc_addr;
  reg [DW-1:0] cyc_data;

  pfce_timer #(.W(TW)) u_timer (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_load(tload),
    .i_count(tcount),
    .o_done(tdone)
  );

  ////////////////////////////////////////////////////////////////////////////
  // six-cycle sequence table; upper address bits zero since flash ignores them, except the sector address on step 5
  always @*
  begin
    cyc_addr = {{(AW-12){1'b0}}, `PFCE_UNLOCK1_ADDR};
    cyc_data = `PFCE_UNLOCK1_DATA;
    case (step_q)
      3'h0, 3'h3:
      begin
        cyc_addr = {{(AW-12){1'b0}}, `PFCE_UNLOCK1_ADDR};
        cyc_data = `PFCE_UNLOCK1_DATA;
      end
      3'h1, 3'h4:
      begin
        cyc_addr = {{(AW-12){1'b0}}, `PFCE_UNLOCK2_ADDR};
        cyc_data = `PFCE_UNLOCK2_DATA;
      end
      3'h2:
      begin
        cyc_addr = {{(AW-12){1'b0}}, `PFCE_UNLOCK1_ADDR};
        cyc_data = `PFCE_SETUP_ERASE;
      end
      3'h5:
      begin
        // sector erase puts the sector address on the last cycle
        if (op_q == `PFCE_OP_SECTOR)
        begin
          cyc_addr = addr_q;
          cyc_data = `PFCE_CONF_SECTOR;
        end
        else if (op_q == `PFCE_OP_LOCK)
          cyc_data = `PFCE_CONF_LOCK;
        else
          cyc_data = `PFCE_CONF_CHIP;
      end
      default:
      begin
        cyc_addr = {{(AW-12){1'b0}}, `PFCE_UNLOCK1_ADDR};
        cyc_data = `PFCE_UNLOCK1_DATA;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer loads on each state entry except the return to S_IDLE
  always @*
  begin
    tload = 1'b0;
    tcount = {TW{1'b0}};
    case (st_q)
      S_IDLE:
      begin
        tload = i_cmd_valid;
        tcount = (i_cmd_op == `PFCE_OP_RESET) ? `PFCE_RESET_CYC : `PFCE_SETUP_CYC;
      end
      S_SETUP:
      begin
        tload = tdone;
        tcount = `PFCE_PULSE_CYC;
      end
      S_PULSE:
      begin
        tload = tdone;
        tcount = `PFCE_SETUP_CYC;
      end
      S_HOLD:
      begin
        tload = tdone;
        if (step_q == 3'h5)
          tcount = (op_q == `PFCE_OP_SECTOR) ? SECTOR_CYC : ERASE_CYC;
        else
          tcount = `PFCE_SETUP_CYC;
      end
      S_RSETUP:
      begin
        tload = 1'b1;
        tcount = `PFCE_ACCESS_CYC + 2;
      end
      default:
      begin
        tload = 1'b0;
        tcount = {TW{1'b0}};
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk)
  begin
    dq_s1_q <= i_flash_dq_in;
    dq_s2_q <= dq_s1_q;
  end

  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      st_q <= S_IDLE;
      op_q <= `PFCE_OP_READ;
      step_q <= 3'h0;
      addr_q <= {AW{1'b0}};
      o_cmd_ready <= 1'b1;
      o_rd_valid <= 1'b0;
      o_rd_data <= `PFCE_ERASED_BYTE;
      o_done <= 1'b0;
      o_flash_addr <= {AW{1'b0}};
      o_flash_dq_out <= {DW{1'b0}};
      o_flash_dq_oe <= 1'b0;
      o_flash_select_n <= 1'b1;
      o_flash_gate_n <= 1'b1;
      o_flash_strobe_n <= 1'b1;
      o_flash_reset_n <= 1'b1;
      o_flash_override <= 1'b0;
    end
    else
    begin
      o_rd_valid <= 1'b0;
      o_done <= 1'b0;
      case (st_q)
        S_IDLE:
        begin
          if (i_cmd_valid)
          begin
            o_cmd_ready <= 1'b0;
            op_q <= i_cmd_op;
            addr_q <= i_cmd_addr;
            step_q <= 3'h0;
            o_flash_override <= i_override;
            if (i_cmd_op == `PFCE_OP_READ)
            begin
              o_flash_addr <= i_cmd_addr;
              o_flash_select_n <= 1'b0;
              st_q <= S_RSETUP;
            end
            else if (i_cmd_op == `PFCE_OP_RESET)
            begin
              o_flash_reset_n <= 1'b0;
              o_flash_select_n <= 1'b1;
              st_q <= S_RESET;
            end
            else
            begin
              o_flash_gate_n <= 1'b1;
              st_q <= S_SETUP;
            end
          end
        end
        S_RSETUP:
        begin
          o_flash_gate_n <= 1'b0;
          st_q <= S_RWAIT;
        end
        S_RWAIT:
        begin
          // two extra cycles cover the input synchroniser latency
          if (tdone)
          begin
            o_rd_data <= dq_s2_q;
            o_rd_valid <= 1'b1;
            o_flash_gate_n <= 1'b1;
            o_flash_select_n <= 1'b1;
            o_cmd_ready <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        S_SETUP:
        begin
          // address settles with select low before the strobe falls
          o_flash_addr <= cyc_addr;
          o_flash_dq_out <= cyc_data;
          o_flash_dq_oe <= 1'b1;
          o_flash_select_n <= 1'b0;
          if (tdone)
          begin
            o_flash_strobe_n <= 1'b0;
            st_q <= S_PULSE;
          end
        end
        S_PULSE:
        begin
          if (tdone)
          begin
            o_flash_strobe_n <= 1'b1;
            st_q <= S_HOLD;
          end
        end
        S_HOLD:
        begin
          // address and data held past the rising strobe, then released
          if (tdone)
          begin
            o_flash_select_n <= 1'b1;
            o_flash_dq_oe <= 1'b0;
            if (step_q == 3'h5)
              st_q <= S_ERASE;
            else
            begin
              step_q <= step_q + 3'h1;
              st_q <= S_SETUP;
            end
          end
        end
        S_ERASE:
        begin
          // no pin activity while erase runs; flash would drop it anyway
          if (tdone)
          begin
            o_flash_override <= 1'b0;
            o_done <= 1'b1;
            o_cmd_ready <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        S_RESET:
        begin
          if (tdone)
          begin
            o_flash_reset_n <= 1'b1;
            o_done <= 1'b1;
            o_cmd_ready <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        default:
          st_q <= S_IDLE;
      endcase
    end
  end
endmodule

// ===== tb/pfce_host_props.sv
// pfce_host_props.sv: pin and handshake assertions for the flash host
// assumes: bound into pfce_host, ports matched by name
`timescale 1ns/1ps
module pfce_host_props (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_cmd_valid,
  input wire logic [2:0] i_cmd_op,
  input wire logic o_cmd_ready,
  input wire logic o_rd_valid,
  input wire logic o_done,
  input wire logic [16:0] o_flash_addr,
  input wire logic [7:0] o_flash_dq_out,
  input wire logic o_flash_dq_oe,
  input wire logic o_flash_select_n,
  input wire logic o_flash_gate_n,
  input wire logic o_flash_strobe_n,
  input wire logic o_flash_reset_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  //////////////////////////////////////////////////////////////////////
  strobe_gate_a: assert property (
    !o_flash_strobe_n |-> o_flash_gate_n && !o_flash_select_n) else $error("bad write pins");
  write_drive_a: assert property (
    !o_flash_strobe_n |-> o_flash_dq_oe && !o_cmd_ready) else $error("write not driven");
  read_float_a: assert property (
    !o_flash_gate_n |-> !o_flash_dq_oe && o_flash_strobe_n) else $error("read contention");
  pulse_width_a: assert property (
    $fell(o_flash_strobe_n) |=> !o_flash_strobe_n) else $error("strobe too short");
  data_hold_a: assert property (
    !o_flash_strobe_n |-> $stable(o_flash_addr) && $stable(o_flash_dq_out))
    else $error("moved under strobe");
  rise_select_a: assert property (
    $rose(o_flash_strobe_n) |-> !o_flash_select_n && o_flash_dq_oe) else $error("early release");
  cmd_addr_a: assert property (
    $rose(o_flash_strobe_n) && o_flash_dq_out != 8'h55 && o_flash_dq_out != 8'h30
    |-> o_flash_addr[11:0] == 12'h555) else $error("command address wrong");
  unlock_two_a: assert property (
    $rose(o_flash_strobe_n) && o_flash_dq_out == 8'h55 |-> o_flash_addr[10:0] == 11'h2aa)
    else $error("second unlock address wrong");
  read_time_a: assert property (
    i_cmd_valid && o_cmd_ready && i_cmd_op == 3'h0 |-> ##8 o_rd_valid) else $error("read late");
  reset_idle_a: assert property (
    !o_flash_reset_n |-> o_flash_select_n && !o_flash_dq_oe && !o_cmd_ready)
    else $error("pins busy in flash reset");
  done_pulse_a: assert property (
    o_done |=> !o_done) else $error("done too long");
  cover property (o_rd_valid);
  cover property (o_done);
  cover property ($rose(o_flash_strobe_n) && o_flash_dq_out == 8'h30);
endmodule

// ===== tb/pfce_flash_model.sv
// pfce_flash_model.sv: behavioural byte-wide flash with erase and boot lockout
// assumes: host drives pins from a 40 MHz clock, strobe-controlled writes
`timescale 1ns/1ps
module pfce_flash_model (
  input wire logic [16:0] i_addr,
  input wire logic [7:0] i_dq,
  input wire logic i_select_n,
  input wire logic i_gate_n,
  input wire logic i_strobe_n,
  input wire logic i_reset_n,
  input wire logic i_override,
  output wire logic [7:0] o_dq
);
  logic [7:0] mem [0:131071];
  logic [7:0] last_q = 8'h00;
  logic [16:0] a_q = 17'h00000;
  logic lock_q = 1'b0;
  logic [19:0] seq [0:4] = '{20'h555aa, 20'h2aa55, 20'h55580, 20'h555aa, 20'h2aa55};
  int step = 0;
  realtime busy_t = 0.0;
  //////////////////////////////////////////////////////////////////////
  function automatic logic [2:0] rg(input logic [16:0] a);
    rg = a[16] ? 3'd4 : a[15] ? 3'd3 : a[14] ? (a[13] ? 3'd2 : 3'd1) : 3'd0;
  endfunction
  // released lines show the inverse of the last byte so a late sample is caught
  assign o_dq = (!i_select_n && !i_gate_n && i_strobe_n && i_reset_n) ? mem[i_addr] : ~last_q;
  always @(posedge i_gate_n) last_q = mem[i_addr];
  initial for (int j = 0; j < 131072; j++) mem[j] = 8'(j) ^ 8'h3c;
  task automatic erase(input int r);
    for (int j = 0; j < 131072; j++)
      if ((r == 5 || rg(17'(j)) == r) && !(rg(17'(j)) == 0 && lock_q && !i_override))
        mem[j] = 8'hff;
  endtask
  always @(negedge i_strobe_n) if (!i_select_n) a_q = i_addr;
  always @(posedge i_strobe_n or negedge i_reset_n)
  begin
    if (!i_reset_n)
      step = 0;
    else if (!i_select_n && i_gate_n && $realtime >= busy_t)
    begin
      if (step < 5)
        step = ({(step == 1 || step == 4) ? {1'b0, a_q[10:0]} : a_q[11:0], i_dq} == seq[step])
          ? step + 1 : 0;
      else
      begin
        step = 0;
        busy_t = $realtime + 1000.0;
        if (i_dq == 8'h10 && a_q[11:0] == 12'h555) erase(5);
        else if (i_dq == 8'h30) erase(rg(i_addr));
        else if (i_dq == 8'h40 && a_q[11:0] == 12'h555) lock_q = 1'b1;
      end
    end
  end
endmodule

// ===== tb/pfce_host_tb.sv
// pfce_host_tb.sv: fixed and random reads and erase sequences against the flash model
// assumes: erase waits shortened to 50 cycles
`timescale 1ns/1ps
module pfce_host_tb;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_cmd_valid = 1'b0;
  logic [2:0] i_cmd_op = 3'h0;
  logic [16:0] i_cmd_addr = 17'h00000;
  logic i_override = 1'b0;
  wire o_cmd_ready, o_rd_valid, o_done, oe, sel_n, gate_n, strobe_n, rst_n, ovr;
  wire [7:0] o_rd_data, dq_out, dq_in;
  wire [16:0] f_addr;
  int bad_count = 0;
  int n_checks = 0;
  logic [4:0] er = 5'h00;
  always #12.5 i_clk = ~i_clk;
  pfce_host #(.ERASE_CYC(50), .SECTOR_CYC(50)) dut (.i_clk(i_clk), .i_reset(i_reset),
    .i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op), .i_cmd_addr(i_cmd_addr),
    .i_override(i_override), .o_cmd_ready(o_cmd_ready), .o_rd_valid(o_rd_valid),
    .o_rd_data(o_rd_data), .o_done(o_done), .o_flash_addr(f_addr), .o_flash_dq_out(dq_out),
    .o_flash_dq_oe(oe), .i_flash_dq_in(dq_in), .o_flash_select_n(sel_n),
    .o_flash_gate_n(gate_n), .o_flash_strobe_n(strobe_n), .o_flash_reset_n(rst_n),
    .o_flash_override(ovr));
  pfce_flash_model flash (.i_addr(f_addr), .i_dq(dq_out), .i_select_n(sel_n),
    .i_gate_n(gate_n), .i_strobe_n(strobe_n), .i_reset_n(rst_n), .i_override(ovr), .o_dq(dq_in));
  //////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] expb(input logic [16:0] a);
    logic [2:0] r;
    r = a[16] ? 3'd4 : a[15] ? 3'd3 : a[14] ? (a[13] ? 3'd2 : 3'd1) : 3'd0;
    expb = er[r] ? 8'hff : (a[7:0] ^ 8'h3c);
  endfunction
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task run(input logic [2:0] op, input logic [16:0] a, input logic ov);
    int k;
    while (o_cmd_ready !== 1'b1) @(negedge i_clk);
    @(negedge i_clk);
    i_cmd_valid = 1'b1;
    i_cmd_op = op;
    i_cmd_addr = a;
    i_override = ov;
    @(negedge i_clk);
    i_cmd_valid = 1'b0;
    k = 0;
    // answer pulses last one cycle, so look just after each edge
    while (o_rd_valid !== 1'b1 && o_done !== 1'b1 && k < 4000)
    begin
      @(posedge i_clk);
      #1;
      k++;
    end
    chk8({6'h00, o_rd_valid, o_done}, op == 3'h0 ? 8'h02 : 8'h01);
  endtask
  task probe;
    logic [16:0] pts [10] = '{17'h00000, 17'h00555, 17'h03fff, 17'h04000, 17'h05fff,
      17'h06000, 17'h07fff, 17'h08000, 17'h10000, 17'h1ffff};
    logic [16:0] a;
    for (int n = 0; n < 14; n++)
    begin
      a = n < 10 ? pts[n] : 17'($urandom);
      run(3'h0, a, 1'b0);
      chk8(o_rd_data, expb(a));
    end
  endtask
  initial
  begin
    void'($urandom(32'hf6fa33d5));
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    i_reset = 1'b0;
    probe;
    run(3'h2, 17'h04000 | 17'($urandom & 32'h1fff), 1'b0);
    er[1] = 1'b1;
    run(3'h2, 17'h0a000, 1'b0);
    er[3] = 1'b1;
    probe;
    run(3'h3, 17'h00000, 1'b0);
    run(3'h2, 17'h01000, 1'b0);
    run(3'h1, 17'h00000, 1'b0);
    er = er | 5'h1e;
    probe;
    run(3'h1, 17'h00000, 1'b1);
    er = 5'h1f;
    run(3'h4, 17'h00000, 1'b0);
    probe;
    wrap_up;
  end
  initial
  begin
    #400000;
    bad_count++;
    wrap_up;
  end
endmodule
bind pfce_host pfce_host_props u_props (.*);
